/* rtl/conv_ctl.sv */
// What this block does
// - any apb write to converter_control_two aborts the running sequence.
// - with fast clear off a completion flag clears only by writing one to it.
// - with fast clear on and compare off, reading result n clears flag n.
// - with fast clear on and compare on, writing result n clears flag n.
// - with stop-clock set, entering stop switches to the internal clock and the sequence runs on.
// - the bus prescaler has no influence on the internal clock pace in stop.
// - the external trigger is ignored while converting in stop.
// - a conversion crossing a run/stop transition writes no result, sets no flag, does no compare.
// - with stop-clock clear, a sequence running at stop entry aborts and restarts at stop exit.
// - in stop the compare and sequence-done interrupts can still be raised.
// - bit 4 picks level or edge trigger detection.
// - bit 3 picks the trigger polarity.
// - level/polarity pair: 00 falling, 01 rising, 10 low level, 11 high level.
module conv_ctl
  import conv_ctl_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [conv_ctl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          stop_mode,
  input  wire logic                          internal_conversion_clock_tick,
  input  wire logic                          prescale_tick,
  input  wire logic                          ext_trigger,
  input  wire logic                          start_sequence,
  input  wire logic [conv_ctl_pkg::RES_W-1:0] sample_value,
  input  wire logic [conv_ctl_pkg::RES_W-1:0] compare_value,
  output logic                               compare_irq,
  output logic                               sequence_done_irq,
  output logic                               using_internal_clock
);
  import conv_ctl_pkg::*;

  typedef struct packed {
    logic [7:0]            ctl2;
    logic [NCONV-1:0]      ccf;
    logic [NCONV-1:0]      compare_enable;
    logic [NCONV*RES_W-1:0] res;
    seq_state_t            st;
    logic [2:0]            idx;
    logic [3:0]            cnt;
    logic                  tainted;
    logic                  restart;
    logic                  seq_done;
    logic                  stop_s1;
    logic                  stop_s2;
    logic                  stop_d;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  cmp_irq;
    logic                  seq_irq;
    logic                  internal_conversion_clock_on;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t next_q;
  logic       trig_hit;

  trig_detect u_trig (
    .pclk                 (pclk),
    .presetn              (presetn),
    .trig_async           (ext_trigger),
    .trigger_level_select (q.ctl2[TRIG_LVL_BIT]),
    .trigger_polarity     (q.ctl2[TRIG_POL_BIT]),
    .trig_hit             (trig_hit)
  );

  always_comb begin
    logic             acc;
    logic             wr;
    logic             rd;
    logic             in_res;
    logic [2:0]       ridx;
    logic             stop_edge;
    logic             stopped;
    logic             tick;
    logic             go;
    logic [NCONV-1:0] set_ccf;
    logic [NCONV-1:0] clr_ccf;
    logic [RES_W-1:0] conv;
    next_q    = q;
    acc       = psel & penable & ~q.pready;
    wr        = acc & pwrite;
    rd        = acc & ~pwrite;
    in_res    = (paddr >= RES_BASE) && (paddr <= RES_LAST) && (paddr[1:0] == 2'b00);
    ridx      = paddr[4:2];
    set_ccf   = '0;
    clr_ccf   = '0;
    conv      = '0;
    // stop request crosses from the power controller: two flops first
    next_q.stop_s1 = stop_mode;
    next_q.stop_s2 = q.stop_s1;
    next_q.stop_d  = q.stop_s2;
    stopped   = q.stop_s2;
    stop_edge = q.stop_s2 ^ q.stop_d;
    // internal tick pace is not the prescaled bus pace in stop
    tick      = stopped ? internal_conversion_clock_tick : prescale_tick;
    next_q.internal_conversion_clock_on = stopped & q.ctl2[STOP_INTERNAL_CONVERSION_CLOCK_BIT];

    // apb slave: one wait state in the access phase, pready registered
    next_q.pready  = acc;
    next_q.pslverr = 1'b0;
    if (acc) begin
      next_q.prdata = '0;
      unique case (1'b1)
        paddr == CTL2_ADDR: next_q.prdata[7:0] = q.ctl2;
        paddr == FLAG_ADDR: next_q.prdata[NCONV-1:0] = q.ccf;
        paddr == COMPARE_ENABLE_ADDR: next_q.prdata[NCONV-1:0] = q.compare_enable;
        paddr == STAT_ADDR: begin
          next_q.prdata[ST_BUSY_BIT] = (q.st == SEQ_CONV);
          next_q.prdata[ST_STOP_BIT] = q.internal_conversion_clock_on;
          next_q.prdata[ST_SEQ_BIT]  = q.seq_done;
          next_q.prdata[ST_PEND_BIT] = q.restart;
        end
        in_res:             next_q.prdata[RES_W-1:0] = q.res[ridx*RES_W +: RES_W];
        default:            next_q.pslverr = 1'b1;
      endcase
      if (pwrite) begin
        next_q.prdata = '0;
      end
    end
    if (wr && paddr == COMPARE_ENABLE_ADDR) begin
      next_q.compare_enable = pwdata[NCONV-1:0];
    end
    if (wr && paddr == STAT_ADDR && pwdata[ST_SEQ_BIT]) begin
      next_q.seq_done = 1'b0;
    end

    // flag clearing: write-one or fast clear on result access
    if (wr && paddr == FLAG_ADDR && !q.ctl2[FAST_CLR_BIT]) begin
      clr_ccf = pwdata[NCONV-1:0];
    end
    if (acc && in_res && q.ctl2[FAST_CLR_BIT]) begin
      if (!q.compare_enable[ridx] && rd) begin
        clr_ccf[ridx] = 1'b1;
      end
      if (q.compare_enable[ridx] && wr) begin
        clr_ccf[ridx] = 1'b1;
      end
    end

    // sequencer
    go = start_sequence | (q.ctl2[TRIG_EN_BIT] & trig_hit & ~stopped);
    unique case (q.st)
      SEQ_IDLE: begin
        if (go) begin
          next_q.st      = SEQ_CONV;
          next_q.idx     = '0;
          next_q.cnt     = '0;
          next_q.tainted = 1'b0;
        end
      end
      SEQ_CONV: begin
        // a run/stop change mid-conversion poisons just this one
        if (stop_edge) begin
          next_q.tainted = 1'b1;
        end
        if (tick) begin
          next_q.cnt = q.cnt + CNT_ONE;
        end
        if (tick && (q.cnt == 4'((stopped ? CONV_INTERNAL_CONVERSION_CLOCK_CYC : CONV_BUS_CYC) - 1))) begin
          next_q.cnt     = '0;
          next_q.tainted = 1'b0;
          if (!(q.tainted || stop_edge)) begin
            conv = sample_value;
            next_q.res[q.idx*RES_W +: RES_W] = conv;
            set_ccf[q.idx] = ~q.compare_enable[q.idx] | (conv > compare_value);
            if (q.compare_enable[q.idx] && conv > compare_value) begin
              next_q.cmp_irq = q.ctl2[CMP_IE_BIT];
            end
          end
          if (q.idx == IDX_LAST) begin
            next_q.st       = SEQ_IDLE;
            next_q.seq_done = 1'b1;
            next_q.seq_irq  = q.ctl2[SEQ_IE_BIT];
          end else begin
            next_q.idx = q.idx + 3'h1;
          end
        end
        // without stop clocking the sequence is parked and rerun at exit
        if (stop_edge && stopped && !q.ctl2[STOP_INTERNAL_CONVERSION_CLOCK_BIT]) begin
          next_q.st      = SEQ_HOLD;
          next_q.restart = 1'b1;
        end
      end
      SEQ_HOLD: begin
        if (!stopped) begin
          next_q.st      = SEQ_CONV;
          next_q.idx     = '0;
          next_q.cnt     = '0;
          next_q.tainted = 1'b0;
          next_q.restart = 1'b0;
        end
      end
    endcase

    // interrupts rise only at a completion with enable set, then drop with their source; seq flag cleared by software
    if (!q.seq_done || !q.ctl2[SEQ_IE_BIT]) begin
      next_q.seq_irq = next_q.seq_done & q.ctl2[SEQ_IE_BIT];
    end
    if (!(|(q.ccf & q.compare_enable)) || !q.ctl2[CMP_IE_BIT]) begin
      next_q.cmp_irq = next_q.cmp_irq & q.ctl2[CMP_IE_BIT] & (|(q.ccf & q.compare_enable) | |set_ccf);
    end

    // set wins over clear in the same cycle
    next_q.ccf = (q.ccf & ~clr_ccf) | set_ccf;

    // control write: every write aborts, even same value
    if (wr && paddr == CTL2_ADDR) begin
      next_q.ctl2    = pwdata[7:0] & CTL2_MASK;
      next_q.st      = SEQ_IDLE;
      next_q.cnt     = '0;
      next_q.idx     = '0;
      next_q.restart = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q      <= '0;
      q.ctl2 <= CTL2_RESET;
      q.st   <= SEQ_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign prdata               = q.prdata;
  assign pready               = q.pready;
  assign pslverr              = q.pslverr;
  assign compare_irq          = q.cmp_irq;
  assign sequence_done_irq    = q.seq_irq;
  assign using_internal_clock = q.internal_conversion_clock_on;
endmodule

/* rtl/conv_ctl_pkg.sv */
package conv_ctl_pkg;

  // register map, byte addresses on a 32-bit apb word grid
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTL2_IDX = 8'h02;
  localparam logic [7:0] CTL2_ADDR = 8'h08;
  localparam logic [7:0] FLAG_ADDR = 8'h10;
  localparam logic [7:0] COMPARE_ENABLE_ADDR = 8'h14;
  localparam logic [7:0] STAT_ADDR = 8'h18;
  localparam logic [7:0] RES_BASE = 8'h40;
  localparam logic [7:0] RES_LAST = 8'h5c;

  // field positions in converter_control_two
  localparam int unsigned FAST_CLR_BIT = 6;
  localparam int unsigned STOP_INTERNAL_CONVERSION_CLOCK_BIT = 5;
  localparam int unsigned TRIG_LVL_BIT = 4;
  localparam int unsigned TRIG_POL_BIT = 3;
  localparam int unsigned TRIG_EN_BIT = 2;
  localparam int unsigned SEQ_IE_BIT = 1;
  localparam int unsigned CMP_IE_BIT = 0;
  localparam logic [7:0] CTL2_RESET = 8'h00;
  localparam logic [7:0] CTL2_MASK = 8'h7f;

  // sequencer geometry and timing
  localparam int unsigned NCONV = 8;
  localparam int unsigned RES_W = 12;
  localparam int unsigned CONV_BUS_CYC = 14;
  localparam int unsigned CONV_INTERNAL_CONVERSION_CLOCK_CYC = 4;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [2:0] IDX_LAST = 3'h7;

  // status register bit positions
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_STOP_BIT = 1;
  localparam int unsigned ST_SEQ_BIT = 2;
  localparam int unsigned ST_PEND_BIT = 3;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CONV,
    SEQ_HOLD
  } seq_state_t;

endpackage

/* rtl/trig_detect.sv */
// external trigger sensitivity decode
module trig_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trig_async,
  input  wire logic trigger_level_select,
  input  wire logic trigger_polarity,
  output logic      trig_hit
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } trig_state_t;

  trig_state_t q;
  trig_state_t next_q;
  logic        act;
  logic        act_prev;

  always_comb begin
    next_q      = q;
    next_q.s1   = trig_async;
    next_q.s2   = q.s1;
    next_q.prev = q.s2;
  end

  // polarity flips the sense so one edge/level check serves both
  assign act      = trigger_polarity ? q.s2 : ~q.s2;
  assign act_prev = trigger_polarity ? q.prev : ~q.prev;
  assign trig_hit = trigger_level_select ? act : (act & ~act_prev);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

/* verif/conv_ctl_monitor.sv */
module conv_ctl_monitor
  import conv_ctl_pkg::*;
(
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [conv_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                      prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  input wire logic                             stop_mode,
  input wire logic                             using_internal_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access taken at this edge; past the result block is unmapped
  wire logic take = psel && penable && !pready;
  wire logic ctl  = take && paddr == CTL2_ADDR;
  wire logic far  = take && paddr > RES_LAST;

  property p_wait; take |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_cause; pready |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("ready unasked");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_far; far && !pwrite |=> pslverr && prdata == 32'h0; endproperty
  a_far: assert property (p_far) else $error("unmapped answer");
  property p_ctl; ctl |=> !pslverr; endproperty
  a_ctl: assert property (p_ctl) else $error("control refused");
  property p_rsv; ctl && !pwrite |=> prdata[31:7] == 25'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  // stop passes a two-flop sync, so look two samples back
  property p_on; $rose(using_internal_clock) |-> $past(stop_mode, 2); endproperty
  a_on: assert property (p_on) else $error("internal clock without stop");
  property p_off; $fell(using_internal_clock) |-> !$past(stop_mode, 2); endproperty
  a_off: assert property (p_off) else $error("internal clock left in stop");

  c_ctl: cover property (ctl && pwrite);
  c_far: cover property (far);
  c_on: cover property ($rose(using_internal_clock));
endmodule

bind conv_ctl conv_ctl_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_mode(stop_mode), .using_internal_clock(using_internal_clock));

/* verif/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import conv_ctl_pkg::*;
  logic        pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        stop_mode, internal_conversion_clock_tick, prescale_tick, ext_trigger, start_sequence;
  logic        compare_irq, sequence_done_irq, using_internal_clock;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] sample_value, compare_value;
  int          num_errors, tests_run;

  conv_ctl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .internal_conversion_clock_tick(internal_conversion_clock_tick), .prescale_tick(prescale_tick),
    .ext_trigger(ext_trigger), .start_sequence(start_sequence), .sample_value(sample_value),
    .compare_value(compare_value), .compare_irq(compare_irq), .sequence_done_irq(sequence_done_irq),
    .using_internal_clock(using_internal_clock));

  // clock and the two conversion paces
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    internal_conversion_clock_tick <= ~internal_conversion_clock_tick;
    prescale_tick <= ~prescale_tick;
  end

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask

  // one apb transfer; pready sampled at the rising edge, request released at that same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a slave that never answers ends the run here
    if (n >= 20) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask

  task automatic go;
    @(posedge pclk);
    start_sequence <= 1'b1;
    @(posedge pclk);
    start_sequence <= 1'b0;
  endtask

  task automatic wdone;
    int n;
    n = 0;
    do begin
      apb(1'b0, STAT_ADDR, 32'h0);
      n++;
    end while (rd[ST_SEQ_BIT] !== 1'b1 && n < 200);
    chk("done", 32'h1, rd[ST_SEQ_BIT]);
  endtask

  task automatic t_regs;
    rdc(CTL2_ADDR, 32'h0, "ctl rst");
    wr(CTL2_ADDR, 32'hff);
    rdc(CTL2_ADDR, 32'h7f, "ctl rsv");
    rdc(8'h60, 32'h0, "unmapped");
    chk("slverr", 32'h1, err);
    wr(CTL2_ADDR, 32'h0);
  endtask

  task automatic t_abort;
    go();
    rdc(STAT_ADDR, 32'h1, "busy");
    wr(CTL2_ADDR, 32'h0);
    rdc(STAT_ADDR, 32'h0, "aborted");
  endtask

  task automatic t_w1c;
    wr(COMPARE_ENABLE_ADDR, 32'h0);
    go();
    wdone();
    rdc(RES_BASE, 32'h5, "res0");
    rdc(FLAG_ADDR, 32'hff, "no rd clr");
    wr(FLAG_ADDR, 32'h1);
    rdc(FLAG_ADDR, 32'hfe, "w1c");
    wr(FLAG_ADDR, 32'hfe);
    wr(STAT_ADDR, 32'h4);
  endtask

  task automatic t_fast;
    wr(COMPARE_ENABLE_ADDR, 32'h2);
    wr(CTL2_ADDR, 32'h43);
    go();
    wdone();
    chk("cmp irq", 32'h1, compare_irq);
    chk("seq irq", 32'h1, sequence_done_irq);
    rdc(RES_BASE, 32'h5, "res0");
    rdc(FLAG_ADDR, 32'hfe, "rd clr");
    rdc(RES_BASE + 8'h4, 32'h5, "res1");
    rdc(FLAG_ADDR, 32'hfe, "rd keep");
    wr(RES_BASE + 8'h4, 32'h0);
    rdc(FLAG_ADDR, 32'hfc, "wr clr");
    chk("cmp drop", 32'h0, compare_irq);
    wr(CTL2_ADDR, 32'h0);
    wr(FLAG_ADDR, 32'hfc);
    wr(STAT_ADDR, 32'h4);
  endtask

  // each sensitivity: idle level first, then the active one
  task automatic t_trig;
    for (int m = 0; m < 4; m++) begin
      ext_trigger <= ~m[0];
      wr(CTL2_ADDR, 32'(m * 8 + 4));
      repeat (6) @(posedge pclk);
      apb(1'b0, STAT_ADDR, 32'h0);
      chk("idle", 32'h0, rd[0]);
      ext_trigger <= m[0];
      repeat (6) @(posedge pclk);
      apb(1'b0, STAT_ADDR, 32'h0);
      chk("trig", 32'h1, rd[0]);
      wr(CTL2_ADDR, 32'h0);
    end
  endtask

  task automatic t_stop;
    wr(CTL2_ADDR, 32'h20);
    go();
    stop_mode <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("internal_conversion_clock", 32'h1, using_internal_clock);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("stop run", 32'h3, rd & 32'h3);
    stop_mode <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("bus clk", 32'h0, using_internal_clock);
    wr(CTL2_ADDR, 32'h0);
    go();
    stop_mode <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("held", 32'h8, rd & 32'h8);
    stop_mode <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("restart", 32'h1, rd & 32'h9);
  endtask

  // watchdog at 20000 cycles, well beyond the expected run of under a thousand
  initial begin
    #1_000_000;
    num_errors++;
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, start_sequence, stop_mode, ext_trigger} = 6'h0;
    internal_conversion_clock_tick = 1'b0;
    prescale_tick = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    sample_value = 12'h005;
    compare_value = 12'h000;
    num_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_abort();
    t_w1c();
    t_fast();
    t_trig();
    t_stop();
    print_verdict();
  end
endmodule
